// ### core/vout_pkg.sv
// What this block does
// R1: Trim adds to the commanded target
// R2: Calibration offset also adds, independently of trim
// R3: Trim/offset: signed 16-bit, LSB two-to-minus-13 volt
// R4: Offset writes beyond 0.15 V are refused
// R5: Trim and offset read zero after reset
// R6: Ceiling caps output, accepts 0.1 to 5.5 V
// R7: Target writes above ceiling are discarded
// R8: Ceiling below target limits the output
// R9: Ceiling resets to 1.15 times strapped voltage
// R10: Margin high uses upper level, 1.05x reset
// R11: Margin low uses lower level, 0.95x reset
// R12: Slew at programmed rate, not at turn-on/off
// R13: Largest positive rate code means fastest transition
// R14: Target: unsigned 16-bit, LSB two-to-minus-13 volt
// R15: Ceiling and margins share the target encoding
// R16: Reference = selected level (target or margin) + trim + offset, clamped to 0..ceiling
package vout_pkg;

  // Command codes of the setpoint group
  localparam logic [7:0] CMD_TARGET = 8'h21;
  localparam logic [7:0] CMD_TRIM = 8'h22;
  localparam logic [7:0] CMD_CAL = 8'h23;
  localparam logic [7:0] CMD_CEIL = 8'h24;
  localparam logic [7:0] CMD_MHIGH = 8'h25;
  localparam logic [7:0] CMD_MLOW = 8'h26;
  localparam logic [7:0] CMD_SLEW = 8'h27;

  // Reset values
  localparam logic [15:0] TRIM_RESET = 16'h0000;
  localparam logic [15:0] CAL_RESET = 16'h0000;
  localparam logic [15:0] SLEW_RESET = 16'hBA00;

  // Voltage codes are volts times 8192
  localparam logic signed [15:0] OFFSET_LIMIT = 16'sh04CC;
  localparam logic [15:0] LEVEL_MIN = 16'h0334;
  localparam logic [15:0] CEIL_MAX = 16'hB000;
  localparam logic [15:0] TARGET_MIN = 16'h0E67;

  // Strap scaling, in percent
  localparam logic [6:0] CEIL_PCT = 7'd115;
  localparam logic [6:0] MHIGH_PCT = 7'd105;
  localparam logic [6:0] MLOW_PCT = 7'd95;
  localparam logic [6:0] PCT_DEN = 7'd100;

  // Slew rate, Linear-11, compared in V/ms times 65536
  localparam logic [15:0] SLEW_FASTEST = 16'h7BFF;
  localparam logic [40:0] RATE_MIN_Q16 = 41'h0000000199A;
  localparam logic [40:0] RATE_MAX_Q16 = 41'h00000040000;

  // Clock and ramp step: LSB per cycle in 32-bit fraction = rate_q16 * 2^29 / cycles per ms
  localparam int CLK_PERIOD_NS = 4;
  localparam int CYCLES_PER_MS = 1000000 / CLK_PERIOD_NS;
  localparam logic [11:0] STEP_MUL = 12'((2 ** 29) / CYCLES_PER_MS);

  typedef enum logic [1:0] {SEL_NORMAL, SEL_LOW, SEL_HIGH} margin_sel_t;

endpackage

// ### core/bound_check.sv
`timescale 1ns/1ns
module bound_check
  import vout_pkg::*;
(
  // Value and inclusive limits
  input wire logic [15:0] value_i,
  input wire logic [15:0] lo_i,
  input wire logic [15:0] hi_i,
  // Verdict
  output logic ok_o
);

  assign ok_o = (value_i >= lo_i) && (value_i <= hi_i);

endmodule

// ### core/setpoint_ramp.sv
`timescale 1ns/1ns
module setpoint_ramp
  import vout_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  // Goal and step
  input wire logic [15:0] target_i,
  input wire logic [31:0] step_i,
  input wire logic jump_i,
  // Ramped reference
  output logic [15:0] ref_o,
  output logic busy_o
);

  typedef enum logic {TRACK, RAMP} ramp_state_t;

  ramp_state_t state_r;
  logic [47:0] acc_r;
  logic [47:0] goal;
  logic [47:0] step_w;

  assign goal = {target_i, 32'h0000_0000};
  assign step_w = {16'h0000, step_i};
  assign ref_o = acc_r[47:32];
  assign busy_o = (state_r == RAMP);

  // Fraction bits keep slow rates exact over a long ramp
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_r <= 48'h0000_0000_0000;
      state_r <= TRACK;
    end else if (jump_i) begin
      acc_r <= goal; // see R13
      state_r <= TRACK;
    end else begin
      case (state_r)
        TRACK: begin
          if (acc_r[47:32] != target_i) begin
            state_r <= RAMP;
          end
        end
        RAMP: begin
          if (goal > acc_r) begin
            if (goal - acc_r <= step_w) begin
              acc_r <= goal;
              state_r <= TRACK;
            end else begin
              acc_r <= acc_r + step_w; // see R12
            end
          end else if (acc_r - goal <= step_w) begin
            acc_r <= goal;
            state_r <= TRACK;
          end else begin
            acc_r <= acc_r - step_w; // see R12
          end
        end
        default: state_r <= TRACK;
      endcase
    end
  end

endmodule

// ### core/output_voltage_setpoint_regs.sv
`timescale 1ns/1ns
module output_voltage_setpoint_regs
  import vout_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  // Command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic rsp_refused_o,
  output logic [15:0] rsp_rdata_o,
  // Strap and operating mode
  input wire logic [15:0] strap_vout_i,
  input wire margin_sel_t margin_sel_i,
  input wire logic output_enable_i,
  // Reference out
  output logic [15:0] vref_o,
  output logic slewing_o
);

  logic [15:0] target_r;
  logic [15:0] trim_r;
  logic [15:0] cal_r;
  logic [15:0] ceil_r;
  logic [15:0] mhigh_r;
  logic [15:0] mlow_r;
  logic [15:0] slew_r;
  logic defaults_pending_r;
  logic rsp_valid_r;
  logic rsp_refused_r;
  logic [15:0] rsp_rdata_r;
  logic [15:0] eff_r;
  logic [31:0] step_r;
  logic en_d_r;
  logic slewing_r;

  logic wr_hit;
  logic trim_ok;
  logic cal_ok;
  logic ceil_ok;
  logic level_ok;
  logic target_ok;
  logic slew_ok;
  logic code_known;
  logic write_ok;
  logic [15:0] rdata_nxt;
  logic [15:0] sel_level;
  logic signed [17:0] sum_nxt;
  logic [15:0] eff_nxt;
  logic [40:0] slew_q16;
  logic [22:0] ceil_dflt;
  logic [22:0] mhigh_dflt;
  logic [22:0] mlow_dflt;
  logic jump;
  logic [15:0] ramp_ref;
  logic ramp_busy;

  // Linear-11 rate to V/ms times 65536; negative mantissa gives zero
  function automatic logic [40:0] rate_q16(input logic [15:0] v);
    logic [5:0] sh;
    sh = 6'({v[15], v[15:11]} + 6'd16);
    if (v[10]) begin
      return 41'h0;
    end
    return {31'h0, v[9:0]} << sh[4:0];
  endfunction

  assign wr_hit = cmd_valid_i && cmd_write_i && !defaults_pending_r;
  assign slew_q16 = rate_q16(slew_r);

  // Offsets are two's complement counts of 2^-13 V
  assign trim_ok = ($signed(cmd_wdata_i) <= OFFSET_LIMIT) && ($signed(cmd_wdata_i) >= -OFFSET_LIMIT); // see R3
  assign cal_ok = trim_ok; // see R4
  assign slew_ok = (cmd_wdata_i == SLEW_FASTEST) ||
                   ((rate_q16(cmd_wdata_i) >= RATE_MIN_Q16) && (rate_q16(cmd_wdata_i) <= RATE_MAX_Q16));

  bound_check u_ceil_chk (
    .value_i(cmd_wdata_i),
    .lo_i(LEVEL_MIN),
    .hi_i(CEIL_MAX),
    .ok_o(ceil_ok)
  );

  bound_check u_level_chk (
    .value_i(cmd_wdata_i),
    .lo_i(LEVEL_MIN),
    .hi_i(ceil_r),
    .ok_o(level_ok)
  );

  bound_check u_target_chk (
    .value_i(cmd_wdata_i),
    .lo_i(TARGET_MIN),
    .hi_i(ceil_r),
    .ok_o(target_ok)
  );

  // Strap-derived defaults, loaded once after reset release
  assign ceil_dflt = ({7'h00, strap_vout_i} * {16'h0000, CEIL_PCT}) / {16'h0000, PCT_DEN};
  assign mhigh_dflt = ({7'h00, strap_vout_i} * {16'h0000, MHIGH_PCT}) / {16'h0000, PCT_DEN};
  assign mlow_dflt = ({7'h00, strap_vout_i} * {16'h0000, MLOW_PCT}) / {16'h0000, PCT_DEN};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      defaults_pending_r <= 1'b1;
    end else begin
      defaults_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trim_r <= TRIM_RESET; // see R5
    end else if (wr_hit && cmd_code_i == CMD_TRIM && trim_ok) begin
      trim_r <= cmd_wdata_i; // see R4
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cal_r <= CAL_RESET; // see R5
    end else if (wr_hit && cmd_code_i == CMD_CAL && cal_ok) begin
      cal_r <= cmd_wdata_i; // see R4
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ceil_r <= 16'h0000;
    end else if (defaults_pending_r) begin
      ceil_r <= ceil_dflt[15:0]; // see R9
    end else if (wr_hit && cmd_code_i == CMD_CEIL && ceil_ok) begin
      ceil_r <= cmd_wdata_i; // see R6
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mhigh_r <= 16'h0000;
    end else if (defaults_pending_r) begin
      mhigh_r <= mhigh_dflt[15:0]; // see R10
    end else if (wr_hit && cmd_code_i == CMD_MHIGH && level_ok) begin
      mhigh_r <= cmd_wdata_i; // see R15
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mlow_r <= 16'h0000;
    end else if (defaults_pending_r) begin
      mlow_r <= mlow_dflt[15:0]; // see R11
    end else if (wr_hit && cmd_code_i == CMD_MLOW && level_ok) begin
      mlow_r <= cmd_wdata_i; // see R15
    end
  end

  // The target itself starts at the strap value
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      target_r <= 16'h0000;
    end else if (defaults_pending_r) begin
      target_r <= strap_vout_i; // see R14
    end else if (wr_hit && cmd_code_i == CMD_TARGET && target_ok) begin
      target_r <= cmd_wdata_i; // see R7
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      slew_r <= SLEW_RESET;
    end else if (wr_hit && cmd_code_i == CMD_SLEW && slew_ok) begin
      slew_r <= cmd_wdata_i;
    end
  end

  // Decode and read mux
  always_comb begin
    code_known = 1'b1;
    write_ok = 1'b0;
    rdata_nxt = 16'h0000;
    case (cmd_code_i)
      CMD_TARGET: begin
        rdata_nxt = target_r;
        write_ok = target_ok;
      end
      CMD_TRIM: begin
        rdata_nxt = trim_r;
        write_ok = trim_ok;
      end
      CMD_CAL: begin
        rdata_nxt = cal_r;
        write_ok = cal_ok;
      end
      CMD_CEIL: begin
        rdata_nxt = ceil_r;
        write_ok = ceil_ok;
      end
      CMD_MHIGH: begin
        rdata_nxt = mhigh_r;
        write_ok = level_ok;
      end
      CMD_MLOW: begin
        rdata_nxt = mlow_r;
        write_ok = level_ok;
      end
      CMD_SLEW: begin
        rdata_nxt = slew_r;
        write_ok = slew_ok;
      end
      default: code_known = 1'b0;
    endcase
  end

  // One response per command, one cycle later
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rsp_valid_r <= 1'b0;
      rsp_refused_r <= 1'b0;
      rsp_rdata_r <= 16'h0000;
    end else begin
      rsp_valid_r <= cmd_valid_i;
      rsp_refused_r <= cmd_valid_i && (!code_known || defaults_pending_r || (cmd_write_i && !write_ok));
      if (cmd_valid_i && !cmd_write_i) begin
        rsp_rdata_r <= rdata_nxt;
      end
    end
  end

  // Effective reference: pick, add both corrections, clamp to [0, ceiling]
  always_comb begin
    case (margin_sel_i)
      SEL_HIGH: sel_level = mhigh_r; // see R10
      SEL_LOW: sel_level = mlow_r; // see R11
      default: sel_level = target_r;
    endcase
    sum_nxt = $signed({2'b00, sel_level}) + $signed({{2{trim_r[15]}}, trim_r}) // see R1
              + $signed({{2{cal_r[15]}}, cal_r}); // see R2
    if (sum_nxt < 18'sd0) begin
      eff_nxt = 16'h0000;
    end else if (sum_nxt[16:0] > {1'b0, ceil_r}) begin
      eff_nxt = ceil_r; // see R8
    end else begin
      eff_nxt = sum_nxt[15:0]; // see R16
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      eff_r <= 16'h0000;
      step_r <= 32'h0000_0000;
      en_d_r <= 1'b0;
      slewing_r <= 1'b0;
    end else begin
      eff_r <= eff_nxt; // see R6
      step_r <= {13'h0, slew_q16[18:0]} * {20'h0, STEP_MUL};
      en_d_r <= output_enable_i;
      slewing_r <= ramp_busy;
    end
  end

  // Rate is skipped while off and on the enabling edge
  assign jump = !output_enable_i || !en_d_r || (slew_r == SLEW_FASTEST); // see R12

  setpoint_ramp u_ramp (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .target_i(eff_r),
    .step_i(step_r),
    .jump_i(jump),
    .ref_o(ramp_ref),
    .busy_o(ramp_busy)
  );

  assign rsp_valid_o = rsp_valid_r;
  assign rsp_refused_o = rsp_refused_r;
  assign rsp_rdata_o = rsp_rdata_r;
  assign vref_o = ramp_ref;
  assign slewing_o = slewing_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_TRIM_ADD: assert property ( // see R1
    (margin_sel_i == SEL_NORMAL && cal_r == 16'h0000 && !trim_r[15] &&
     ({1'b0, target_r} + {1'b0, trim_r}) <= {1'b0, ceil_r})
    |=> eff_r == $past(target_r) + $past(trim_r))
    else $error("trim not added to target");

  AST_CAL_ADD: assert property ( // see R2
    (margin_sel_i == SEL_NORMAL && trim_r == 16'h0000 && !cal_r[15] &&
     ({1'b0, target_r} + {1'b0, cal_r}) <= {1'b0, ceil_r})
    |=> eff_r == $past(target_r) + $past(cal_r))
    else $error("offset not added to target");

  AST_TRIM_REFUSE: assert property ( // see R4
    wr_hit && cmd_code_i == CMD_TRIM && !trim_ok |=> $stable(trim_r) && rsp_refused_o)
    else $error("out of range trim accepted");

  AST_OFFSETS_ZERO: assert property (@(posedge clk_i) disable iff (1'b0) // see R5
    $fell(reset_i) |-> trim_r == 16'h0000 && cal_r == 16'h0000)
    else $error("offsets not zero after reset");

  AST_CEIL_REFUSE: assert property ( // see R6
    wr_hit && cmd_code_i == CMD_CEIL && cmd_wdata_i > CEIL_MAX |=> $stable(ceil_r) && rsp_refused_o)
    else $error("ceiling above 5.5 V accepted");

  AST_TARGET_REFUSE: assert property ( // see R7
    wr_hit && cmd_code_i == CMD_TARGET && cmd_wdata_i > ceil_r |=> $stable(target_r) && rsp_refused_o)
    else $error("target above ceiling accepted");

  AST_CEIL_CAP: assert property ( // see R8
    $stable(ceil_r) |-> ##1 eff_r <= $past(ceil_r))
    else $error("reference above ceiling");

  AST_CEIL_DEFAULT: assert property ( // see R9
    $fell(defaults_pending_r) |-> ceil_r == 16'(({7'h00, $past(strap_vout_i)} * {16'h0000, CEIL_PCT}) /
                                                {16'h0000, PCT_DEN}))
    else $error("ceiling default wrong");

  AST_MARGIN_HIGH: assert property ( // see R10
    (margin_sel_i == SEL_HIGH && trim_r == 16'h0000 && cal_r == 16'h0000 && mhigh_r <= ceil_r)
    |=> eff_r == $past(mhigh_r))
    else $error("margin high not selected");

  AST_MARGIN_LOW: assert property ( // see R11
    (margin_sel_i == SEL_LOW && trim_r == 16'h0000 && cal_r == 16'h0000 && mlow_r <= ceil_r)
    |=> eff_r == $past(mlow_r))
    else $error("margin low not selected");

  AST_TURN_ON: assert property ( // see R12
    !output_enable_i |=> vref_o == $past(eff_r))
    else $error("reference slewed while off");

  AST_SLEW_BOUND: assert property ( // see R12
    output_enable_i && en_d_r && slew_r != SLEW_FASTEST
    |=> (vref_o - $past(vref_o) <= 16'h0001) || ($past(vref_o) - vref_o <= 16'h0001))
    else $error("ramp step too large");

  AST_FASTEST: assert property ( // see R13
    slew_r == SLEW_FASTEST |=> vref_o == $past(eff_r))
    else $error("fastest rate did not jump");

  COV_MARGIN_RAMP: cover property (margin_sel_i == SEL_HIGH ##1 slewing_o [*4]);
  COV_TRIM_REFUSED: cover property (wr_hit && cmd_code_i == CMD_TRIM && !trim_ok);
  COV_RAMP_DONE: cover property ($fell(slewing_o) && output_enable_i);

endmodule

// ### verif/cmd_host.sv
`timescale 1ns/1ns
module cmd_host (
  // Clock
  input wire logic clk_i,
  // Command side
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] cmd_wdata_o,
  // Response side
  input wire logic rsp_valid_i,
  input wire logic rsp_refused_i,
  input wire logic [15:0] rsp_rdata_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
  end

  // One command per call; the answer stands only in the cycle after the taking edge
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic seen, output logic refused, output logic [15:0] rd);
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_code_o = code;
    cmd_wdata_o = wd;
    @(posedge clk_i);
    #1;
    seen = rsp_valid_i;
    refused = rsp_refused_i;
    rd = rsp_rdata_i;
    // Released lines show a changed value so a stale sample cannot pass
    cmd_valid_o = 1'b0;
    cmd_write_o = ~wr;
    cmd_code_o = ~code;
    cmd_wdata_o = ~wd;
  endtask
endmodule

// ### verif/output_voltage_setpoint_regs_test.sv
`timescale 1ns/1ns
module output_voltage_setpoint_regs_test;
  import vout_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid;
  logic cmd_write;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata;
  logic rsp_valid;
  logic rsp_refused;
  logic [15:0] rsp_rdata;
  logic [15:0] strap = 16'h2000;
  margin_sel_t margin_sel = SEL_NORMAL;
  logic enable = 1'b0;
  logic [15:0] vref;
  logic slewing;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  logic [7:0] codes [7] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
  logic [15:0] resets [7] = '{16'h2000, 16'h0000, 16'h0000, 16'h24CC, 16'h2199, 16'h1E66, 16'hBA00};

  always #2 clk = ~clk;

  output_voltage_setpoint_regs uut (
    .clk_i(clk), .reset_i(reset),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_code_i(cmd_code), .cmd_wdata_i(cmd_wdata),
    .rsp_valid_o(rsp_valid), .rsp_refused_o(rsp_refused), .rsp_rdata_o(rsp_rdata),
    .strap_vout_i(strap), .margin_sel_i(margin_sel), .output_enable_i(enable),
    .vref_o(vref), .slewing_o(slewing)
  );

  cmd_host host (
    .clk_i(clk),
    .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write), .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata),
    .rsp_valid_i(rsp_valid), .rsp_refused_i(rsp_refused), .rsp_rdata_i(rsp_rdata)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] wd, input logic exp_ref);
    logic seen;
    logic refd;
    logic [15:0] rd;
    host.xfer(1'b1, code, wd, seen, refd, rd);
    check("write status", {14'h0, 1'b1, exp_ref}, {14'h0, seen, refd});
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic exp_ref);
    logic seen;
    logic refd;
    logic [15:0] data;
    host.xfer(1'b0, code, 16'h0000, seen, refd, data);
    check("read status", {14'h0, 1'b1, exp_ref}, {14'h0, seen, refd});
    check("read data", exp, data);
  endtask

  // Reference path needs two edges to move, plus margin for the jump
  task automatic vchk(input logic [15:0] exp);
    repeat (4) @(posedge clk);
    #1;
    check("reference", exp, vref);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(codes[i], resets[i], 1'b0);
    end
    vchk(16'h2000);
    rd(8'h28, 16'h0000, 1'b1);
    for (int i = 1; i < 3; i++) begin
      wr(codes[i], 16'h04CD, 1'b1);
      wr(codes[i], 16'hFB33, 1'b1);
      rd(codes[i], 16'h0000, 1'b0);
      wr(codes[i], 16'h04CC, 1'b0);
      rd(codes[i], 16'h04CC, 1'b0);
      wr(codes[i], 16'hFB34, 1'b0);
      rd(codes[i], 16'hFB34, 1'b0);
    end
    vchk(16'h1668);
    wr(8'h22, 16'h0100, 1'b0);
    wr(8'h23, 16'h0010, 1'b0);
    vchk(16'h2110);
    wr(8'h24, 16'h0333, 1'b1);
    wr(8'h24, 16'hB001, 1'b1);
    wr(8'h24, 16'h0334, 1'b0);
    vchk(16'h0334);
    wr(8'h24, 16'hB000, 1'b0);
    rd(8'h24, 16'hB000, 1'b0);
    wr(8'h24, 16'h24CC, 1'b0);
    wr(8'h21, 16'h24CD, 1'b1);
    rd(8'h21, 16'h2000, 1'b0);
    wr(8'h21, 16'h0E66, 1'b1);
    wr(8'h21, 16'h24CC, 1'b0);
    vchk(16'h24CC);
    wr(8'h21, 16'h2000, 1'b0);
    wr(8'h25, 16'h24CD, 1'b1);
    wr(8'h25, 16'h0333, 1'b1);
    wr(8'h25, 16'h2200, 1'b0);
    wr(8'h26, 16'h0333, 1'b1);
    wr(8'h26, 16'h1C00, 1'b0);
    margin_sel = SEL_HIGH;
    vchk(16'h2310);
    margin_sel = SEL_LOW;
    vchk(16'h1D10);
    margin_sel = SEL_NORMAL;
    vchk(16'h2110);
    wr(8'h27, 16'hCA01, 1'b1);
    wr(8'h27, 16'hBE00, 1'b1);
    wr(8'h27, 16'hA199, 1'b1);
    wr(8'h27, 16'hA19A, 1'b0);
    wr(8'h27, 16'hCA00, 1'b0);
    wr(8'h27, 16'h7BFF, 1'b0);
    rd(8'h27, 16'h7BFF, 1'b0);
    enable = 1'b1;
    wr(8'h21, 16'h2100, 1'b0);
    vchk(16'h2210);
    wr(8'h21, 16'h2000, 1'b0);
    vchk(16'h2110);
    wr(8'h27, 16'hBA00, 1'b0);
    wr(8'h21, 16'h2010, 1'b0);
    repeat (20) @(posedge clk);
    #1;
    check("slow ramp", 16'h0003, {14'h0, slewing, vref <= 16'h2112});
    // About 30 cycles per step at 1 V/ms, so 16 steps land near 490 cycles
    for (n = 20; n < 1000 && vref !== 16'h2120; n++) begin
      @(posedge clk);
      #1;
    end
    check("ramp length", 16'h0001, {15'h0, n >= 450 && n <= 540});
    vchk(16'h2120);
    check("ramp done", 16'h0000, {15'h0, slewing});
    enable = 1'b0;
    wr(8'h21, 16'h2100, 1'b0);
    vchk(16'h2210);
    // Fastest rate that still ramps, 4 V/ms: about 7.6 cycles per step, so 16 steps land near 125 cycles
    enable = 1'b1;
    wr(8'h27, 16'hCA00, 1'b0);
    wr(8'h21, 16'h2110, 1'b0);
    for (n = 0; n < 1000 && vref !== 16'h2220; n++) begin
      @(posedge clk);
      #1;
    end
    check("fast ramp length", 16'h0001, {15'h0, n >= 110 && n <= 140});
    results();
  end
endmodule
